// file: src/smtr_readout.sv
// Top of the SMBus temperature readout: byte-register slave, address straps and conversion results.
// Assumes the host drives SCL; SDA is open drain and resolved outside from the enable.
// Link pins are sampled by the 25 MHz core clock, far above the bus rate.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - The slave answers only write byte, read byte, send byte and receive byte transfers.
// - A receive byte returns the register last picked by a command byte.
// - The slave address is one of nine values chosen by two tri-level strap pins.
// - Channel one and channel two results are readable at command codes 00h and 01h.
// - Each result is an unsigned byte with 1 degree per LSB and 128 degrees for the MSB.
// - Read data goes out on the data line most significant bit first.
// - Any result below zero degrees is stored as 00h.
// - Once started, the two channels are converted in turn, each result written at the end of its own window.
// - Each channel integrates for a nominal 120 ms before its result lands.
// - With a negative thermistor offset at 17h, a result below zero clips to zero.
// - The local channel also has a low byte of three fraction bits from 0.5 to 0.125 degree.
// - The thermistor result is the sense resistor voltage as a fraction of the reference.
// - Read byte is address with write, command byte, repeated start, address with read, one data byte.
module smtr_readout
  import smtr_pkg::*;
#(
  parameter int INTEG_CYCLES = smtr_pkg::INTEG_CYCLES
) (
  input wire logic core_clk, // Core clock, 25 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic smb_scl_in, // SMBus clock from the host
  input wire logic smb_sda_in, // SMBus data as seen on the wire
  output logic smb_sda_out, // SMBus data drive value, always low
  output logic smb_sda_oe_n, // Low while pulling SDA low
  input wire logic [1:0] addr_pin0_level, // Strap pin 0 level code
  input wire logic [1:0] addr_pin1_level, // Strap pin 1 level code
  input wire logic run_enable, // Starts continuous conversion
  input wire logic signed [smtr_pkg::RAW_W-1:0] local_raw, // Local sensor, eighths of a degree
  input wire logic [smtr_pkg::RAW_W-1:0] thermistor_sense_input, // Sense ratio across series_sense_resistor
  output logic conv_channel // Channel now integrating
);
  import smtr_pkg::*;

  localparam int SYNC_W = 7;

  typedef struct packed {
    smtr_fsm_t fsm;
    logic [2:0] bitcnt;
    logic byte_done;
    logic [7:0] shreg;
    logic rd_dir;
    logic [7:0] ptr;
    logic [7:0] offset;
    logic sda_oe_n;
    logic sda_out;
    logic scl_prev;
    logic sda_prev;
    logic [ADDR_W-1:0] slave_addr;
    logic addr_ok;
    logic [1:0] boot_cnt;
  } smtr_top_t;

  smtr_top_t s_ff;
  smtr_top_t nxt_s;
  logic [SYNC_W-1:0] sync_q;
  logic scl;
  logic sda;
  logic run_sync;
  logic [1:0] lvl0;
  logic [1:0] lvl1;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic rx_done;
  logic [TEMP_W-1:0] ch1_temp;
  logic [TEMP_W-1:0] ch2_temp;
  logic [TEMP_W-1:0] local_frac;
  logic [TEMP_W-1:0] rd_byte;

  if (INTEG_CYCLES < 2) begin : g_bad_integ
    $error("smtr_readout: integration window must be at least two cycles");
  end

  // Strap level to table index; an undefined code is taken as floating
  function automatic logic [1:0] lvl_index(input logic [1:0] lvl);
    case (lvl)
      LVL_GND: lvl_index = 2'h0;
      LVL_VCC: lvl_index = 2'h2;
      default: lvl_index = 2'h1;
    endcase
  endfunction

  // Nine addresses from two three-state straps
  function automatic logic [ADDR_W-1:0] addr_lookup(input logic [1:0] p1, input logic [1:0] p0);
    logic [3:0] idx;
    idx = 4'(lvl_index(p1)) * 4'(LVL_COUNT) + 4'(lvl_index(p0));
    addr_lookup = ADDR_TABLE[idx];
  endfunction

  // Register read decode; unmapped codes read zero
  function automatic logic [TEMP_W-1:0] reg_read(input logic [7:0] code, input logic [7:0] c1,
                                                 input logic [7:0] c2, input logic [7:0] fr,
                                                 input logic [7:0] off);
    case (code)
      REG_CH1_TEMP: reg_read = c1;
      REG_CH2_TEMP: reg_read = c2;
      REG_LOCAL_FRAC: reg_read = fr;
      REG_THERM_OFFSET: reg_read = off;
      default: reg_read = UNMAPPED_READ;
    endcase
  endfunction

  // Pins from the link and the straps cross into the core domain
  smtr_sync #(
    .W(SYNC_W)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({run_enable, addr_pin1_level, addr_pin0_level, smb_sda_in, smb_scl_in}),
    .sync_out(sync_q)
  );

  assign scl = sync_q[0];
  assign sda = sync_q[1];
  assign lvl0 = sync_q[3:2];
  assign lvl1 = sync_q[5:4];
  assign run_sync = sync_q[6];

  // Conversion sequencer and result registers
  smtr_converter #(
    .INTEG_CYCLES(INTEG_CYCLES)
  ) u_conv (
    .core_clk(core_clk),
    .rst(rst),
    .run_enable(run_sync),
    .local_raw(local_raw),
    .thermistor_sense_input(thermistor_sense_input),
    .therm_offset(s_ff.offset),
    .ch1_temp(ch1_temp),
    .ch2_temp(ch2_temp),
    .local_frac(local_frac),
    .conv_channel(conv_channel)
  );

  // Bus events on synchronised pins; SDA changes only while SCL is low
  // Held off until the straps are caught: the synchroniser leaves reset low while the wire idles high
  assign scl_rise = s_ff.addr_ok & scl & ~s_ff.scl_prev;
  assign scl_fall = s_ff.addr_ok & ~scl & s_ff.scl_prev;
  assign start_det = s_ff.addr_ok & s_ff.scl_prev & scl & s_ff.sda_prev & ~sda;
  assign stop_det = s_ff.addr_ok & s_ff.scl_prev & scl & ~s_ff.sda_prev & sda;
  assign rx_done = scl_fall & s_ff.byte_done;

  // The whole byte is copied into the shifter at once, so a result update cannot split it
  assign rd_byte = reg_read(s_ff.ptr, ch1_temp, ch2_temp, local_frac, s_ff.offset);

  // Slave state machine and register writes
  always_comb begin
    nxt_s = s_ff;
    nxt_s.scl_prev = scl;
    nxt_s.sda_prev = sda;
    // Straps are caught a few edges after release, once the synchroniser holds them
    if (!s_ff.addr_ok) begin
      if (s_ff.boot_cnt == BOOT_DONE) begin
        nxt_s.slave_addr = addr_lookup(lvl1, lvl0);
        nxt_s.addr_ok = 1'b1;
      end else begin
        nxt_s.boot_cnt = s_ff.boot_cnt + 2'h1;
      end
    end
    // Receiving states share one bit shifter
    if ((s_ff.fsm == SMTR_ADDR || s_ff.fsm == SMTR_CMD || s_ff.fsm == SMTR_WDATA) &&
        scl_rise && !s_ff.byte_done) begin
      nxt_s.shreg = {s_ff.shreg[6:0], sda};
      if (s_ff.bitcnt == LAST_BIT) begin
        nxt_s.byte_done = 1'b1;
      end else begin
        nxt_s.bitcnt = s_ff.bitcnt + 3'h1;
      end
    end
    if (rx_done) begin
      nxt_s.byte_done = 1'b0;
      nxt_s.bitcnt = FIRST_BIT;
    end
    if (stop_det) begin
      nxt_s.fsm = SMTR_IDLE;
      nxt_s.sda_oe_n = 1'b1;
      nxt_s.byte_done = 1'b0;
    end else if (start_det) begin
      // Repeated start lands here too, which turns a command write into a read byte
      nxt_s.fsm = SMTR_ADDR;
      nxt_s.bitcnt = FIRST_BIT;
      nxt_s.byte_done = 1'b0;
      nxt_s.sda_oe_n = 1'b1;
    end else begin
      case (s_ff.fsm)
        SMTR_ADDR: begin
          if (rx_done) begin
            if (s_ff.addr_ok && s_ff.shreg[7:1] == s_ff.slave_addr) begin
              nxt_s.rd_dir = s_ff.shreg[0];
              nxt_s.sda_oe_n = 1'b0;
              nxt_s.fsm = SMTR_AACK;
            end else begin
              nxt_s.fsm = SMTR_IDLE;
            end
          end
        end
        SMTR_AACK: begin
          if (scl_fall) begin
            if (s_ff.rd_dir) begin
              // Receive byte and read byte both return the selected register
              nxt_s.shreg = rd_byte;
              nxt_s.sda_oe_n = rd_byte[7];
              nxt_s.bitcnt = FIRST_BIT;
              nxt_s.fsm = SMTR_RBYTE;
            end else begin
              nxt_s.sda_oe_n = 1'b1;
              nxt_s.fsm = SMTR_CMD;
            end
          end
        end
        SMTR_CMD: begin
          if (rx_done) begin
            nxt_s.ptr = s_ff.shreg;
            nxt_s.sda_oe_n = 1'b0;
            nxt_s.fsm = SMTR_CACK;
          end
        end
        SMTR_CACK: begin
          if (scl_fall) begin
            nxt_s.sda_oe_n = 1'b1;
            nxt_s.fsm = SMTR_WDATA; // Stop here ends a send byte
          end
        end
        SMTR_WDATA: begin
          if (rx_done) begin
            if (s_ff.ptr == REG_THERM_OFFSET) begin
              nxt_s.offset = s_ff.shreg;
            end
            nxt_s.sda_oe_n = 1'b0;
            nxt_s.fsm = SMTR_DACK;
          end
        end
        SMTR_DACK: begin
          // Only one data byte per write; extra bytes are not acknowledged
          if (scl_fall) begin
            nxt_s.sda_oe_n = 1'b1;
            nxt_s.fsm = SMTR_IDLE;
          end
        end
        SMTR_RBYTE: begin
          if (scl_fall) begin
            if (s_ff.bitcnt == LAST_BIT) begin
              nxt_s.sda_oe_n = 1'b1;
              nxt_s.fsm = SMTR_RACK;
            end else begin
              nxt_s.shreg = {s_ff.shreg[6:0], 1'b0};
              nxt_s.sda_oe_n = s_ff.shreg[6];
              nxt_s.bitcnt = s_ff.bitcnt + 3'h1;
            end
          end
        end
        SMTR_RACK: begin
          // Single-byte read: the host's acknowledge is not acted on
          if (scl_fall) begin
            nxt_s.fsm = SMTR_IDLE;
          end
        end
        SMTR_IDLE: begin
          nxt_s.sda_oe_n = 1'b1;
        end
        default: begin
          nxt_s.fsm = SMTR_IDLE;
          nxt_s.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // State register; line idles high so the edge history starts high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_ff.fsm <= SMTR_IDLE;
      s_ff.bitcnt <= FIRST_BIT;
      s_ff.byte_done <= 1'b0;
      s_ff.shreg <= 8'h00;
      s_ff.rd_dir <= 1'b0;
      s_ff.ptr <= PTR_RESET;
      s_ff.offset <= OFFSET_RESET;
      s_ff.sda_oe_n <= 1'b1;
      s_ff.sda_out <= 1'b0;
      s_ff.scl_prev <= 1'b1;
      s_ff.sda_prev <= 1'b1;
      s_ff.slave_addr <= 7'h00;
      s_ff.addr_ok <= 1'b0;
      s_ff.boot_cnt <= 2'h0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign smb_sda_out = s_ff.sda_out;
  assign smb_sda_oe_n = s_ff.sda_oe_n;
endmodule
`default_nettype wire

// file: src/smtr_pkg.sv
// Shared constants, register map, state encodings and types for the SMBus temperature readout.
// Assumes a single 25 MHz core clock; all other rates are derived from it.
package smtr_pkg;

  // Register command codes
  localparam logic [7:0] REG_CH1_TEMP = 8'h00;
  localparam logic [7:0] REG_CH2_TEMP = 8'h01;
  localparam logic [7:0] REG_THERM_OFFSET = 8'h17;
  localparam logic [7:0] REG_LOCAL_FRAC = 8'h1e;

  // Reset and fixed read values
  localparam logic [7:0] OFFSET_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] TEMP_ZERO = 8'h00;
  localparam logic [7:0] TEMP_MAX = 8'hff;

  // Data widths and field positions
  localparam int TEMP_W = 8;
  localparam int RAW_W = 12;
  localparam int FRAC_W = 3;
  localparam int FRAC_LSB = 5;
  localparam int SUM_W = 14; // Largest sense value plus largest offset must not wrap negative
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam int ADDR_W = 7;

  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int INTEG_TIME_MS = 120;
  localparam int INTEG_CYCLES = (CLK_HZ / 1000) * INTEG_TIME_MS;
  localparam logic [1:0] BOOT_DONE = 2'h3;

  // Tri-level address strap codes
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_FLOAT = 2'h1;
  localparam logic [1:0] LVL_VCC = 2'h2;
  localparam int LVL_COUNT = 3;

  // Nine selectable slave addresses, indexed by pin1 * 3 + pin0
  localparam logic [8:0][6:0] ADDR_TABLE = {
    7'h4e, 7'h4d, 7'h4c, 7'h2b, 7'h2a, 7'h29, 7'h1a, 7'h19, 7'h18
  };

  // Slave state machine, one-hot
  typedef enum logic [8:0] {
    SMTR_IDLE  = 9'h001,
    SMTR_ADDR  = 9'h002,
    SMTR_AACK  = 9'h004,
    SMTR_CMD   = 9'h008,
    SMTR_CACK  = 9'h010,
    SMTR_WDATA = 9'h020,
    SMTR_DACK  = 9'h040,
    SMTR_RBYTE = 9'h080,
    SMTR_RACK  = 9'h100
  } smtr_fsm_t;

endpackage

// file: src/smtr_sync.sv
// Two-flop synchroniser for a group of independent asynchronous levels.
// Assumes each bit is a slow level or a link signal far below the core clock rate.
`timescale 1ns/1ps
`default_nettype none
module smtr_sync #(
  parameter int W = 1
) (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [W-1:0] async_in, // Levels from outside the domain
  output logic [W-1:0] sync_out // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } smtr_sync_t;

  smtr_sync_t s_ff;
  smtr_sync_t nxt_s;

  if (W < 1) begin : g_bad_width
    $error("smtr_sync: width must be at least one");
  end

  // Only the second stage reads the first; nothing else looks at it
  always_comb begin
    nxt_s = s_ff;
    nxt_s.meta = async_in;
    nxt_s.stable = s_ff.meta;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sync_out = s_ff.stable;
endmodule
`default_nettype wire

// file: src/smtr_converter.sv
// Two-channel conversion sequencer with clipping and result registers.
// Assumes the analog front end presents a settled raw result at the end of each integration window.
`timescale 1ns/1ps
`default_nettype none
module smtr_converter
  import smtr_pkg::*;
#(
  parameter int INTEG_CYCLES = smtr_pkg::INTEG_CYCLES
) (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic run_enable, // Synchronised start request
  input wire logic signed [smtr_pkg::RAW_W-1:0] local_raw, // Local die temp, eighths of a degree
  input wire logic [smtr_pkg::RAW_W-1:0] thermistor_sense_input, // Sense ratio, eighths of an LSB
  input wire logic [smtr_pkg::TEMP_W-1:0] therm_offset, // Signed whole-degree offset
  output logic [smtr_pkg::TEMP_W-1:0] ch1_temp, // Local whole degrees
  output logic [smtr_pkg::TEMP_W-1:0] ch2_temp, // Thermistor result
  output logic [smtr_pkg::TEMP_W-1:0] local_frac, // Local fraction byte
  output logic conv_channel // Channel being integrated
);
  localparam int CNT_W = $clog2(INTEG_CYCLES);

  typedef struct packed {
    logic running;
    logic channel;
    logic [CNT_W-1:0] cnt;
    logic [TEMP_W-1:0] ch1;
    logic [TEMP_W-1:0] ch2;
    logic [TEMP_W-1:0] frac;
  } smtr_conv_t;

  smtr_conv_t s_ff;
  smtr_conv_t nxt_s;
  logic signed [SUM_W-1:0] local_sum;
  logic signed [SUM_W-1:0] therm_sum;

  if (INTEG_CYCLES < 2) begin : g_bad_integ
    $error("smtr_converter: integration window must be at least two cycles");
  end

  // Whole degrees of an eighths value; negatives to zero, overflow saturates
  function automatic logic [TEMP_W-1:0] clip_whole(input logic signed [SUM_W-1:0] v);
    if (v < 0) begin
      clip_whole = TEMP_ZERO;
    end else if (v[SUM_W-1:FRAC_W] > (SUM_W-FRAC_W)'(TEMP_MAX)) begin
      clip_whole = TEMP_MAX;
    end else begin
      clip_whole = v[TEMP_W+FRAC_W-1:FRAC_W];
    end
  endfunction

  // Fraction sits in the top three bits, low bits read zero
  function automatic logic [TEMP_W-1:0] clip_frac(input logic signed [SUM_W-1:0] v);
    if (v < 0) begin
      clip_frac = TEMP_ZERO;
    end else begin
      clip_frac = {v[FRAC_W-1:0], {FRAC_LSB{1'b0}}};
    end
  endfunction

  // Local data is already in eighths; thermistor gets the offset in eighths
  assign local_sum = {{(SUM_W-RAW_W){local_raw[RAW_W-1]}}, local_raw};
  assign therm_sum = $signed({{(SUM_W-RAW_W){1'b0}}, thermistor_sense_input}) +
                     $signed({{(SUM_W-TEMP_W-FRAC_W){therm_offset[TEMP_W-1]}}, therm_offset,
                              {FRAC_W{1'b0}}});

  // Sequencer: once started it alternates both channels forever
  always_comb begin
    nxt_s = s_ff;
    if (run_enable) begin
      nxt_s.running = 1'b1;
    end
    if (s_ff.running) begin
      if (s_ff.cnt == CNT_W'(INTEG_CYCLES - 1)) begin
        nxt_s.cnt = '0;
        nxt_s.channel = ~s_ff.channel;
        // Whole result written in one edge so no read sees half an update
        if (!s_ff.channel) begin
          nxt_s.ch1 = clip_whole(local_sum);
          nxt_s.frac = clip_frac(local_sum);
        end else begin
          nxt_s.ch2 = clip_whole(therm_sum);
        end
      end else begin
        nxt_s.cnt = s_ff.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign ch1_temp = s_ff.ch1;
  assign ch2_temp = s_ff.ch2;
  assign local_frac = s_ff.frac;
  assign conv_channel = s_ff.channel;
endmodule
`default_nettype wire

// file: verif/smtr_readout_monitor.sv
// Checker for the readout's bus drive and conversion timing.
// Assumes it is bound to smtr_readout and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module smtr_readout_monitor #(
  parameter int INTEG_CYCLES = smtr_pkg::INTEG_CYCLES
) (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Reset, active high
  input wire logic smb_scl_in, // Bus clock
  input wire logic smb_sda_out, // Data drive value
  input wire logic smb_sda_oe_n, // Low while pulling data low
  input wire logic run_enable, // Start request
  input wire logic conv_channel // Channel integrating
);
  logic prev_ff;
  logic seen_ff;
  logic run_ff;
  logic [31:0] cnt_ff;
  // Cycles since the last channel change; seen_ff skips the first window, whose start is unknown
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_ff <= 1'b0;
      seen_ff <= 1'b0;
      run_ff <= 1'b0;
      cnt_ff <= 32'h0;
    end else begin
      prev_ff <= conv_channel;
      if (run_enable) run_ff <= 1'b1;
      if (conv_channel != prev_ff) begin
        seen_ff <= 1'b1;
        cnt_ff <= 32'h0;
      end else cnt_ff <= cnt_ff + 32'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_sda_low; smb_sda_out == 1'b0; endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data drive value not low");
  property p_reset_vals; $fell(rst) |-> smb_sda_oe_n && !conv_channel; endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("outputs not at reset values");
  property p_period; (conv_channel != prev_ff) && seen_ff |-> cnt_ff == INTEG_CYCLES - 1; endproperty
  a_period: assert property (p_period)
    else $error("window length wrong");
  property p_no_stall; seen_ff |-> cnt_ff < INTEG_CYCLES; endproperty
  a_no_stall: assert property (p_no_stall)
    else $error("conversion stopped");
  property p_needs_run; (conv_channel != prev_ff) |-> run_ff; endproperty
  a_needs_run: assert property (p_needs_run)
    else $error("conversion without start");
  property p_hold; (conv_channel != prev_ff) |=> $stable(conv_channel)[*8]; endproperty
  a_hold: assert property (p_hold)
    else $error("channel changed early");
  property p_drive_low_phase; $changed(smb_sda_oe_n) |-> !$past(smb_scl_in, 2) && !$past(smb_scl_in, 3); endproperty
  a_drive_low_phase: assert property (p_drive_low_phase)
    else $error("data drive moved with clock high");
  property p_idle_release; smb_scl_in [*8] |-> smb_sda_oe_n; endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("data held low while bus idle");
endmodule
bind smtr_readout smtr_readout_monitor #(.INTEG_CYCLES(INTEG_CYCLES)) u_mon (
  .core_clk(core_clk),
  .rst(rst),
  .smb_scl_in(smb_scl_in),
  .smb_sda_out(smb_sda_out),
  .smb_sda_oe_n(smb_sda_oe_n),
  .run_enable(run_enable),
  .conv_channel(conv_channel)
);
`default_nettype wire

// file: verif/smtr_host_model.sv
// SMBus host model: drives the bus clock and open-drain data.
// Assumes a pulled-up resolved wire and calls made at core falling edges.
`timescale 1ns/1ps
`default_nettype none
module smtr_host_model (
  output logic scl, // Bus clock, 320 ns period
  output logic sda_drv, // Host data, 1 releases the line
  input wire logic sda // Resolved data wire
);
  // Bus idles released with the clock high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // One bit; read late in the high phase since the slave answers slowly
  task automatic bit_x(input logic b, output logic r);
    sda_drv = b;
    #80;
    scl = 1'b1;
    #160;
    r = sda;
    scl = 1'b0;
    #80;
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start;
    sda_drv = 1'b1;
    #80;
    scl = 1'b1;
    #160;
    sda_drv = 1'b0;
    #160;
    scl = 1'b0;
    #80;
  endtask
  task automatic stop;
    sda_drv = 1'b0;
    #80;
    scl = 1'b1;
    #160;
    sda_drv = 1'b1;
    #160;
  endtask
  // Byte out MSB first; the ninth bit reads the acknowledge
  task automatic tx(input logic [7:0] b, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ok = ok & ~r;
  endtask
  // Byte in MSB first, then a NACK as only one byte is wanted
  task automatic rx(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(1'b1, r);
  endtask
  // Kinds: 0 write byte, 1 send byte, 2 read byte, 3 receive byte; lone master, so no guard
  task automatic xfer(input logic [6:0] a, input logic [1:0] kind, input logic [7:0] cmd, input logic [7:0] dat,
                      output logic [7:0] q, output logic ok);
    ok = 1'b1;
    q = 8'hff;
    start;
    if (kind == 2'h3) begin
      tx({a, 1'b1}, ok);
      rx(q);
    end else begin
      tx({a, 1'b0}, ok);
      tx(cmd, ok);
      if (kind == 2'h0) tx(dat, ok);
      if (kind == 2'h2) begin
        start;
        tx({a, 1'b1}, ok);
        rx(q);
      end
    end
    stop;
  endtask
endmodule
`default_nettype wire

// file: verif/smtr_readout_bench.sv
// Self-checking bench for the readout: straps, registers and conversion results.
// Assumes the host model, the checker and a pulled-up data wire.
`timescale 1ns/1ps
`default_nettype none
module smtr_readout_bench;
  import smtr_pkg::*;
  localparam int INTEG = 64; // Short windows keep the run brief
  localparam logic [1:0] K_WR = 2'h0;
  localparam logic [1:0] K_SEND = 2'h1;
  localparam logic [1:0] K_RD = 2'h2;
  localparam logic [1:0] K_RECV = 2'h3;
  logic core_clk, rst, scl, host_sda, sda, sda_out, oe_n, run_enable, conv_channel;
  logic [1:0] pin0, pin1;
  logic signed [RAW_W-1:0] local_raw;
  logic [RAW_W-1:0] therm;
  logic [6:0] dev_addr;
  int n_mismatch = 0;
  int checked = 0;
  // Open-drain wire with pull-up; either party may pull it low
  assign sda = host_sda & (oe_n | sda_out);
  smtr_readout #(.INTEG_CYCLES(INTEG)) uut (
    .core_clk(core_clk),
    .rst(rst),
    .smb_scl_in(scl),
    .smb_sda_in(sda),
    .smb_sda_out(sda_out),
    .smb_sda_oe_n(oe_n),
    .addr_pin0_level(pin0),
    .addr_pin1_level(pin1),
    .run_enable(run_enable),
    .local_raw(local_raw),
    .thermistor_sense_input(therm),
    .conv_channel(conv_channel)
  );
  smtr_host_model host (.scl(scl), .sda_drv(host_sda), .sda(sda));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Reset for three cycles, then wait out the strap capture before any start
  task automatic do_reset;
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    repeat (30) @(negedge core_clk);
  endtask
  // One transfer to the selected address; the acknowledge is always judged, the data only for read and receive byte
  task automatic xf(input logic [1:0] k, input logic [7:0] cmd, input logic [7:0] dat, input logic [7:0] exp);
    logic [7:0] q;
    logic ok;
    @(negedge core_clk);
    host.xfer(dev_addr, k, cmd, dat, q, ok);
    check("ack", {7'h0, ok}, 8'h01);
    if (k >= K_RD) check("read_data", q, exp);
  endtask
  task automatic t_address;
    logic [7:0] q;
    logic ok;
    for (int i = 0; i < 9; i++) begin
      pin0 = 2'(i % 3);
      pin1 = 2'(i / 3);
      do_reset();
      dev_addr = ADDR_TABLE[i];
      xf(K_RD, REG_THERM_OFFSET, 8'h00, OFFSET_RESET);
      @(negedge core_clk);
      host.xfer(dev_addr ^ 7'h40, K_RD, REG_CH1_TEMP, 8'h00, q, ok);
      check("foreign_ack", {7'h0, ok}, 8'h00);
    end
  endtask
  // Registers before conversion starts; writes to read-only codes are dropped
  task automatic t_regs;
    xf(K_RD, REG_CH1_TEMP, 8'h00, TEMP_ZERO);
    xf(K_RD, REG_CH2_TEMP, 8'h00, TEMP_ZERO);
    xf(K_RD, REG_LOCAL_FRAC, 8'h00, TEMP_ZERO);
    xf(K_WR, REG_CH1_TEMP, 8'h55, 8'h00);
    xf(K_RD, REG_CH1_TEMP, 8'h00, TEMP_ZERO);
    xf(K_RD, 8'h05, 8'h00, UNMAPPED_READ);
    xf(K_WR, REG_THERM_OFFSET, 8'ha5, 8'h00);
    xf(K_SEND, REG_THERM_OFFSET, 8'h00, 8'h00);
    xf(K_RECV, 8'h00, 8'h00, 8'ha5);
    check("idle_channel", {7'h0, conv_channel}, 8'h00);
  endtask
  // Offset, inputs, two full cycles, then all three results
  task automatic t_conv(input logic [11:0] raw, input logic [11:0] th, input logic [7:0] off,
                        input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] ef);
    xf(K_WR, REG_THERM_OFFSET, off, 8'h00);
    local_raw = raw;
    therm = th;
    run_enable = 1'b1;
    repeat (4 * INTEG) @(negedge core_clk);
    xf(K_RD, REG_CH1_TEMP, 8'h00, e1);
    xf(K_RD, REG_LOCAL_FRAC, 8'h00, ef);
    xf(K_RD, REG_CH2_TEMP, 8'h00, e2);
    xf(K_RECV, 8'h00, 8'h00, e2);
  endtask
  initial begin
    rst = 1'b1;
    pin0 = 2'h0;
    pin1 = 2'h0;
    run_enable = 1'b0;
    local_raw = '0;
    therm = '0;
    dev_addr = 7'h00;
    t_address();
    t_regs();
    t_conv(12'd203, 12'd512, 8'h00, 8'h19, 8'h40, 8'h60);
    t_conv(12'd203, 12'd512, 8'hf0, 8'h19, 8'h30, 8'h60);
    t_conv(12'hff8, 12'd40, 8'hf0, 8'h00, 8'h00, 8'h00);
    t_conv(12'd1120, 12'd2040, 8'h05, 8'h8c, 8'hff, 8'h00);
    t_conv(12'd4, 12'd0, 8'h00, 8'h00, 8'h00, 8'h80);
    t_conv(12'd4, 12'd4095, 8'h7f, 8'h00, 8'hff, 8'h80);
    stop_test();
  end
  // Cuts a hang short; the tests need well under two milliseconds
  initial begin
    #2_000_000;
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
